// File: rtl/ddcbf_fifo.sv
// synchronous FIFO with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`include "ddcbf_map.svh"
module ddcbf_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = `DDCBF_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("ddcbf_fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  // honest flags from the occupancy count
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rd_ptr];
  // storage is not reset; only pointers and count carry control state
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count  <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  property p_no_overfill;
    @(posedge clk_i) disable iff (sys_rst_i)
      !in_ready_o |=> count == (AW+1)'(DEPTH) || $past(pop);
  endproperty
  a_no_overfill: assert property (p_no_overfill)
    else $error("fifo count left full without a pop");
  c_full: cover property (@(posedge clk_i) disable iff (sys_rst_i) !in_ready_o);
endmodule

// File: rtl/ddcbf_map.svh
// constants of the four-channel downconverter and beamformer datapath
// assumes inclusion by bare name from the package and the design modules
`ifndef DDCBF_MAP_SVH
`define DDCBF_MAP_SVH
// ************************************************************
// source selection and widths
// ************************************************************
`define DDCBF_NCH          4
`define DDCBF_SRC_TEST     3'h4
`define DDCBF_ADC_W        16
`define DDCBF_LO_W         32
`define DDCBF_COEF_W       18
`define DDCBF_TAPS         4
`define DDCBF_SAMP_W       24
`define DDCBF_CHAIN_W      32
`define DDCBF_ADJ_W        16
// ************************************************************
// decimation, scaling, averaging and FIFO depth
// ************************************************************
`define DDCBF_STAGE_DEC_MAX 256
`define DDCBF_AVG_SHIFT_MAX 4'hD
`define DDCBF_ROT_SHIFT     15
`define DDCBF_GAIN_SHIFT    14
`define DDCBF_FIFO_DEPTH    16
// ************************************************************
// reset values: default filter taps, Q1.17
// ************************************************************
`define DDCBF_COEF_DEF0    18'h08000
`define DDCBF_COEF_DEF1    18'h08000
`define DDCBF_COEF_DEF2    18'h08000
`define DDCBF_COEF_DEF3    18'h08000
`endif

// File: rtl/ddcbf_pkg.sv
// types shared by the downconverter/beamformer datapath
// assumes ddcbf_map.svh on the include path
`include "ddcbf_map.svh"
package ddcbf_pkg;
  // complex sample with its one-cycle qualifier
  typedef struct packed {
    logic        valid;
    logic [23:0] i;
    logic [23:0] q;
  } ddcbf_iq_t;
  // partial sum carried between boards
  typedef struct packed {
    logic        valid;
    logic [31:0] i;
    logic [31:0] q;
  } ddcbf_chain_t;
  // power meter settings
  typedef struct packed {
    logic [3:0]  avg_shift;
    logic [31:0] thr_hi;
    logic [31:0] thr_lo;
  } ddcbf_mcfg_t;
  // per-channel settings; decimations are held as factor minus one
  typedef struct packed {
    logic [2:0]  src_sel;
    logic [31:0] lo_word;
    logic [7:0]  dec1;
    logic [7:0]  dec2;
    logic        fmt16;
    logic [15:0] rot_cos;
    logic [15:0] rot_sin;
    logic [15:0] gain;
    ddcbf_mcfg_t meter;
  } ddcbf_chcfg_t;
endpackage

// File: rtl/ddcbf_top.sv
// four-channel downconversion and beamforming datapath
// assumes converter samples synchronous to clk_i and one sample per clock
`include "ddcbf_map.svh"
module ddcbf_top #(
  parameter int NCH        = `DDCBF_NCH,
  parameter int FIFO_DEPTH = `DDCBF_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                                   clk_i,
  input  wire logic                                   sys_rst_i,
  // converter samples
  input  wire logic [NCH-1:0][15:0]                   adc_data_i,
  // channel and summer settings
  input  wire ddcbf_pkg::ddcbf_chcfg_t [NCH-1:0]      cfg_i,
  input  wire logic [NCH-1:0]                         sum_en_i,
  input  wire logic [15:0]                            sum_gain_i,
  input  wire ddcbf_pkg::ddcbf_mcfg_t                 sum_meter_i,
  input  wire logic                                   chain_en_i,
  // coefficient load
  input  wire logic                                   coef_wr_i,
  input  wire logic [1:0]                             coef_ch_i,
  input  wire logic [1:0]                             coef_idx_i,
  input  wire logic [17:0]                            coef_data_i,
  // channel outputs
  output ddcbf_pkg::ddcbf_iq_t [NCH-1:0]              ch_out_o,
  // meters and flags, index NCH is the sum
  output logic [NCH:0][31:0]                          pwr_o,
  output logic [NCH:0]                                above_o,
  output logic [NCH:0]                                below_o,
  input  wire logic [NCH:0]                           flag_clr_i,
  output logic                                        irq_o,
  // chain link
  input  wire ddcbf_pkg::ddcbf_chain_t                chain_in_i,
  output logic                                        chain_ready_o,
  output ddcbf_pkg::ddcbf_chain_t                     chain_out_o,
  // acquisition FIFO 1
  output logic [47:0]                                 acq1_data_o,
  output logic                                        acq1_valid_o,
  input  wire logic                                   acq1_ready_i,
  output logic                                        overrun_o
);
  if (NCH != 4) begin : g_chk
    $error("ddcbf_top serves exactly four channels");
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // coarse 16-point sine table; spurs limit the mixer's dynamic range
  function automatic logic signed [15:0] sine16(input logic [3:0] ph);
    case (ph)
      4'h0, 4'h8: sine16 = 16'h0000;
      4'h1, 4'h7: sine16 = 16'h30FB;
      4'h2, 4'h6: sine16 = 16'h5A82;
      4'h3, 4'h5: sine16 = 16'h7641;
      4'h4:       sine16 = 16'h7FFF;
      4'h9, 4'hF: sine16 = 16'hCF05;
      4'hA, 4'hE: sine16 = 16'hA57E;
      4'hC:       sine16 = 16'h8001;
      default:    sine16 = 16'h89BF;
    endcase
  endfunction
  // saturate a wide value into 24 bits
  function automatic logic [23:0] sat24(input logic signed [47:0] v);
    if (v > 48'sh7FFFFF) sat24 = 24'h7FFFFF;
    else if (v < -48'sh800000) sat24 = 24'h800000;
    else sat24 = v[23:0];
  endfunction

  // ************************************************************
  // test generator and coefficient store
  // ************************************************************
  logic        [15:0] tst;
  logic signed [17:0] coef [NCH][`DDCBF_TAPS];
  // ramp test signal shared by all channels
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) tst <= 16'h0000;
    else tst <= tst + 16'h0101;
  end
  // defaults at reset, per-word load afterwards
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (sys_rst_i) begin
        coef[c][0] <= `DDCBF_COEF_DEF0;
        coef[c][1] <= `DDCBF_COEF_DEF1;
        coef[c][2] <= `DDCBF_COEF_DEF2;
        coef[c][3] <= `DDCBF_COEF_DEF3;
      end else if (coef_wr_i && coef_ch_i == 2'(c)) begin
        coef[c][coef_idx_i] <= coef_data_i;
      end
    end
  end

  // ************************************************************
  // channels
  // ************************************************************
  ddcbf_pkg::ddcbf_iq_t [NCH:0] adj;
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic signed [15:0] x;
    logic        [31:0] ph;
    logic signed [31:0] pi, pq;
    logic signed [23:0] mi, mq;
    logic signed [31:0] a1i, a1q, a2i, a2q, next_a1i, next_a1q, next_a2i, next_a2q;
    logic        [7:0]  n1, n2;
    logic               v1, v2, v3;
    logic signed [23:0] s1i, s1q, yi, yq;
    logic signed [23:0] hi [`DDCBF_TAPS];
    logic signed [23:0] hq [`DDCBF_TAPS];
    logic signed [43:0] fi, fq;
    logic signed [40:0] ri, rq;
    logic               vr;
    logic signed [39:0] gi, gq;
    // source select and local oscillator
    assign x  = (cfg_i[c].src_sel == `DDCBF_SRC_TEST) ? tst
              : adc_data_i[cfg_i[c].src_sel[1:0]];
    assign pi = x * sine16(ph[31:28] + 4'h4);
    assign pq = -(x * sine16(ph[31:28]));
    assign next_a1i = a1i + 32'(mi);
    assign next_a1q = a1q + 32'(mq);
    assign next_a2i = a2i + 32'(s1i);
    assign next_a2q = a2q + 32'(s1q);
    // filter taps at the stage-two rate
    always_comb begin
      fi = '0;
      fq = '0;
      for (int k = 0; k < `DDCBF_TAPS; k++) begin
        fi = fi + 44'(hi[k] * coef[c][k]);
        fq = fq + 44'(hq[k] * coef[c][k]);
      end
    end
    // mixer and stage one integrate-and-dump
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        ph <= '0; mi <= '0; mq <= '0; a1i <= '0; a1q <= '0;
        n1 <= '0; v1 <= 1'b0; s1i <= '0; s1q <= '0;
      end else begin
        ph <= ph + cfg_i[c].lo_word;
        mi <= pi[30:7];
        mq <= pq[30:7];
        v1 <= (n1 == cfg_i[c].dec1);
        if (n1 == cfg_i[c].dec1) begin
          n1 <= '0; a1i <= '0; a1q <= '0;
          s1i <= next_a1i[31:8]; s1q <= next_a1q[31:8];
        end else begin
          n1 <= n1 + 8'h01; a1i <= next_a1i; a1q <= next_a1q;
        end
      end
    end
    // stage two and tap delay line; dump gain scales with the factor
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        a2i <= '0; a2q <= '0; n2 <= '0; v2 <= 1'b0;
        for (int k = 0; k < `DDCBF_TAPS; k++) begin hi[k] <= '0; hq[k] <= '0; end
      end else begin
        v2 <= v1 && (n2 == cfg_i[c].dec2);
        if (v1 && n2 == cfg_i[c].dec2) begin
          n2 <= '0; a2i <= '0; a2q <= '0;
          hi[0] <= next_a2i[31:8]; hq[0] <= next_a2q[31:8];
          for (int k = 1; k < `DDCBF_TAPS; k++) begin hi[k] <= hi[k-1]; hq[k] <= hq[k-1]; end
        end else if (v1) begin
          n2 <= n2 + 8'h01; a2i <= next_a2i; a2q <= next_a2q;
        end
      end
    end
    // filter output, format select and channel output
    assign yi = cfg_i[c].fmt16 ? {fi[40:25], 8'h00} : fi[40:17];
    assign yq = cfg_i[c].fmt16 ? {fq[40:25], 8'h00} : fq[40:17];
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        ch_out_o[c] <= '0;
        v3 <= 1'b0;
      end else begin
        v3 <= v2;
        ch_out_o[c] <= '{valid: v3, i: yi, q: yq};
      end
    end
    // phase rotation then gain, both 16-bit
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        ri <= '0; rq <= '0; vr <= 1'b0; adj[c] <= '0;
      end else begin
        vr <= ch_out_o[c].valid;
        ri <= 41'($signed(ch_out_o[c].i) * $signed(cfg_i[c].rot_cos))
            - 41'($signed(ch_out_o[c].q) * $signed(cfg_i[c].rot_sin));
        rq <= 41'($signed(ch_out_o[c].i) * $signed(cfg_i[c].rot_sin))
            + 41'($signed(ch_out_o[c].q) * $signed(cfg_i[c].rot_cos));
        adj[c] <= '{valid: vr, i: sat24(48'(gi >>> `DDCBF_GAIN_SHIFT)),
                    q: sat24(48'(gq >>> `DDCBF_GAIN_SHIFT))};
      end
    end
    assign gi = 40'($signed(ri[38:15]) * $signed(cfg_i[c].gain));
    assign gq = 40'($signed(rq[38:15]) * $signed(cfg_i[c].gain));
  end

  // ************************************************************
  // summation, chain and sum gain
  // ************************************************************
  logic [NCH-1:0]     v_vec;
  logic               sum_fire;
  logic signed [25:0] si, sq;
  logic        [23:0] s24i, s24q;
  logic               pend;
  logic signed [31:0] pi32, pq32, ti, tq;
  logic               take;
  logic signed [47:0] gsi, gsq;
  ddcbf_pkg::ddcbf_iq_t sc;
  logic               fifo_rdy;
  // all enabled channels must deliver in the same cycle
  for (genvar c = 0; c < NCH; c++) begin : g_v
    assign v_vec[c] = adj[c].valid;
  end
  assign sum_fire = (|sum_en_i) && ((v_vec & sum_en_i) == sum_en_i);
  always_comb begin
    si = '0;
    sq = '0;
    for (int c = 0; c < NCH; c++) begin
      if (sum_en_i[c]) begin
        si = si + 26'($signed(adj[c].i));
        sq = sq + 26'($signed(adj[c].q));
      end
    end
  end
  assign s24i = sat24(48'(si));
  assign s24q = sat24(48'(sq));
  // local sum waits for the inbound partial sum when chained
  assign take = pend && (!chain_en_i || chain_in_i.valid) && fifo_rdy;
  assign chain_ready_o = pend && chain_en_i && fifo_rdy;
  assign ti = pi32 + ((chain_en_i && chain_in_i.valid) ? $signed(chain_in_i.i) : 32'sh0);
  assign tq = pq32 + ((chain_en_i && chain_in_i.valid) ? $signed(chain_in_i.q) : 32'sh0);
  assign gsi = 48'(ti * $signed(sum_gain_i));
  assign gsq = 48'(tq * $signed(sum_gain_i));
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pend <= 1'b0; pi32 <= '0; pq32 <= '0; overrun_o <= 1'b0;
      chain_out_o <= '0; sc <= '0;
    end else begin
      if (sum_fire && !(pend && !take)) begin
        pend <= 1'b1;
        pi32 <= 32'(signed'(s24i));
        pq32 <= 32'(signed'(s24q));
      end else if (take) begin
        pend <= 1'b0;
      end
      // a sum that finds the stage still stalled is lost and flagged
      if (sum_fire && pend && !take) overrun_o <= 1'b1;
      chain_out_o <= '{valid: take, i: ti, q: tq};
      sc <= '{valid: take, i: sat24(gsi >>> `DDCBF_GAIN_SHIFT),
              q: sat24(gsq >>> `DDCBF_GAIN_SHIFT)};
    end
  end
  assign adj[NCH] = sc;

  ddcbf_fifo #(.WIDTH(48), .DEPTH(FIFO_DEPTH)) u_acq1 (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (sc.valid),
    .in_ready_o  (fifo_rdy),
    .in_data_i   ({sc.i, sc.q}),
    .out_valid_o (acq1_valid_o),
    .out_ready_i (acq1_ready_i),
    .out_data_o  (acq1_data_o)
  );

  // ************************************************************
  // power meters: channels 0..NCH-1 and the sum at NCH
  // ************************************************************
  for (genvar m = 0; m <= NCH; m++) begin : g_pm
    ddcbf_pkg::ddcbf_mcfg_t mc;
    logic signed [48:0] pw;
    logic        [31:0] avg;
    logic signed [32:0] dif, stp;
    logic        [3:0]  sh;
    assign mc  = (m == NCH) ? sum_meter_i : cfg_i[m % NCH].meter;
    assign sh  = (mc.avg_shift > `DDCBF_AVG_SHIFT_MAX) ? `DDCBF_AVG_SHIFT_MAX : mc.avg_shift;
    assign pw  = 49'($signed(adj[m].i) * $signed(adj[m].i))
               + 49'($signed(adj[m].q) * $signed(adj[m].q));
    assign dif = $signed({1'b0, pw[47:16]}) - $signed({1'b0, avg});
    assign stp = dif >>> sh;
    assign pwr_o[m] = avg;
    // the flag set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        avg <= '0; above_o[m] <= 1'b0; below_o[m] <= 1'b0;
      end else begin
        if (adj[m].valid) avg <= avg + stp[31:0];
        above_o[m] <= (adj[m].valid && avg > mc.thr_hi) || (above_o[m] && !flag_clr_i[m]);
        below_o[m] <= (adj[m].valid && avg < mc.thr_lo) || (below_o[m] && !flag_clr_i[m]);
      end
    end
  end
  assign irq_o = |{above_o, below_o};

  // ************************************************************
  // checks
  // ************************************************************
  logic [16:0] gap0;
  // saturated count marks an unknown start, so the first output after reset is not judged
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || ch_out_o[0].valid) gap0 <= sys_rst_i ? 17'h1FFFF : 17'h00001;
    else if (gap0 != 17'h1FFFF) gap0 <= gap0 + 17'h00001;
  end
  property p_valid_pulse;
    ch_out_o[0].valid && (cfg_i[0].dec1 != 8'h00 || cfg_i[0].dec2 != 8'h00)
      |=> !ch_out_o[0].valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than one cycle");
  property p_dec_gap;
    ch_out_o[0].valid && $stable(cfg_i[0]) && $past(ch_out_o[0].valid, 1) == 1'b0
      && gap0 != 17'h1FFFF |-> gap0 == 17'((cfg_i[0].dec1 + 17'h1) * (cfg_i[0].dec2 + 17'h1));
  endproperty
  a_dec_gap: assert property (p_dec_gap) else $error("output spacing not the decimation");
  property p_fmt16;
    ch_out_o[0].valid && $past(cfg_i[0].fmt16, 2) |-> ch_out_o[0].i[7:0] == 8'h00;
  endproperty
  a_fmt16: assert property (p_fmt16) else $error("16-bit format keeps low bits");
  property p_sticky;
    above_o[0] && !flag_clr_i[0] |=> above_o[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without a clear");
  property p_set_wins;
    adj[0].valid && g_pm[0].avg > cfg_i[0].meter.thr_hi && flag_clr_i[0] |=> above_o[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a crossing");
  property p_irq;
    (above_o != '0 || below_o != '0) |-> irq_o ##1 (irq_o || $past(flag_clr_i) != '0);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised by a flag");
  property p_align;
    sum_fire |-> (v_vec & sum_en_i) == sum_en_i && sum_en_i != '0;
  endproperty
  a_align: assert property (p_align) else $error("sum of misaligned samples");
  property p_to_fifo;
    take |=> sc.valid ##1 (acq1_valid_o || $past(acq1_ready_i, 2));
  endproperty
  a_to_fifo: assert property (p_to_fifo) else $error("scaled sum missing from FIFO");
  property p_chain;
    chain_en_i && take |-> chain_in_i.valid ##1 chain_out_o.valid;
  endproperty
  a_chain: assert property (p_chain) else $error("chain sum without inbound partial");
  c_ch_out: cover property (ch_out_o[0].valid ##[1:300] ch_out_o[0].valid);
  c_sum:    cover property (sum_fire && sum_en_i == 4'hF);
  c_flag:   cover property (above_o[NCH]);
  c_chain:  cover property (chain_en_i && take);
endmodule

// File: verification/ddcbf_acq_sink.sv
// reader model of acquisition FIFO 1, standing where the DMA logic would sit
// assumes the bench clock and reset, and a bench-driven stall request
// ************************************************************
// acquisition reader
// ************************************************************
module ddcbf_acq_sink (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // acquisition side
  input  wire logic [47:0] data_i,
  input  wire logic        valid_i,
  output logic             ready_o,
  // bench control
  input  wire logic        stall_i,
  output int               pops_o,
  output logic [47:0]      last_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a stalled reader holds ready low for as long as the bench asks
  assign ready_o = !stall_i;
  // count words taken; only a valid and ready edge moves a word
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pops_o <= 0;
    end else if (valid_i && ready_o) begin
      pops_o <= pops_o + 1;
      last_o <= data_i;
    end
  end
endmodule

// File: verification/ddcbf_top_tb.sv
// self-checking bench of the downconverter and beamformer datapath
// assumes the design files and ddcbf_acq_sink compiled before it
// ************************************************************
// bench top
// ************************************************************
module ddcbf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0][15:0] adc = '0;
  ddcbf_pkg::ddcbf_chcfg_t [3:0] cfg, nc;
  logic [3:0] sum_en = 4'hF;
  logic chain_en = 1'b0;
  logic coef_wr = 1'b0;
  logic [4:0] flag_clr = '0;
  ddcbf_pkg::ddcbf_chain_t chain_in = '0;
  ddcbf_pkg::ddcbf_iq_t [3:0] ch_out;
  logic [4:0][31:0] pwr;
  logic [4:0] above, below;
  logic irq, chain_rdy, acq_valid, acq_ready, overrun, stall = 1'b1;
  ddcbf_pkg::ddcbf_chain_t chain_out;
  logic [47:0] acq_data, acq_last;
  int pops, n, n_mismatch = 0, cmp_count = 0;
  int d1[4] = '{1, 0, 3, 7};
  int d2[4] = '{0, 1, 1, 7};
  always #4 clk_i = ~clk_i;
  // converter ramp keeps the selected sources moving
  always @(posedge clk_i) adc <= {adc[2:0], adc[0] + 16'h0123};
  ddcbf_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .adc_data_i(adc), .cfg_i(cfg),
    .sum_en_i(sum_en), .sum_gain_i(16'h4000), .sum_meter_i({4'h2, 32'hFFFFFFFF, 32'h0}),
    .chain_en_i(chain_en), .coef_wr_i(coef_wr), .coef_ch_i(2'h2), .coef_idx_i(2'h0),
    .coef_data_i(18'h10000), .ch_out_o(ch_out), .pwr_o(pwr), .above_o(above),
    .below_o(below), .flag_clr_i(flag_clr), .irq_o(irq), .chain_in_i(chain_in),
    .chain_ready_o(chain_rdy), .chain_out_o(chain_out), .acq1_data_o(acq_data),
    .acq1_valid_o(acq_valid), .acq1_ready_i(acq_ready), .overrun_o(overrun));
  ddcbf_acq_sink sink (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .data_i(acq_data),
    .valid_i(acq_valid), .ready_o(acq_ready), .stall_i(stall), .pops_o(pops),
    .last_o(acq_last));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // settings change here inside reset, so all channels restart aligned
  task automatic apply_reset();
    @(posedge clk_i);
    cfg <= nc;
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic gap_check(input int c, input int exp);
    for (n = 0; n < 300 && ch_out[c].valid !== 1'b1; n++) @(negedge clk_i);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ch_out[c].valid !== 1'b1 && n < 300);
    check(n, exp);
  endtask
  task automatic defaults();
    for (int c = 0; c < 4; c++) begin
      nc[c] = '0;
      nc[c].src_sel = 3'h4;
      nc[c].dec1 = 8'h01;
      nc[c].rot_cos = 16'h7FFF;
      nc[c].gain = 16'h4000;
      nc[c].meter = {4'h2, 32'hFFFFFFFF, 32'h0};
    end
  endtask
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    defaults();
    cfg = nc;
    apply_reset();
    check({irq, acq_valid, overrun, chain_rdy, pwr[0]}, 64'h0);
    // per-channel decimation in two stages, own source each
    for (int c = 0; c < 4; c++) begin
      nc[c].src_sel = 3'(c);
      nc[c].dec1 = 8'(d1[c]);
      nc[c].dec2 = 8'(d2[c]);
    end
    nc[0].fmt16 = 1'b1;
    apply_reset();
    for (int c = 0; c < 4; c++) gap_check(c, (d1[c] + 1) * (d2[c] + 1));
    while (ch_out[0].valid !== 1'b1) @(negedge clk_i);
    check(ch_out[0].i[7:0], 8'h00);
    // thresholds: channel 1 falls below, channel 2 rises above
    defaults();
    nc[1].meter.thr_lo = 32'hFFFFFFFF;
    nc[2].meter.thr_hi = 32'h0;
    // ramp power is tiny: a fast meter and extra gain lift the average above zero
    nc[2].meter.avg_shift = 4'h0;
    nc[2].gain = 16'h7FFF;
    apply_reset();
    @(posedge clk_i) coef_wr <= 1'b1;
    @(posedge clk_i) coef_wr <= 1'b0;
    for (n = 0; n < 300 && (below[1] & above[2]) !== 1'b1; n++) @(negedge clk_i);
    check({below[1], above[2], irq}, 3'h7);
    defaults();
    @(posedge clk_i) cfg <= nc;
    repeat (20) @(negedge clk_i);
    check({below[1], above[2]}, 2'h3);
    @(posedge clk_i) flag_clr <= 5'h1F;
    repeat (2) @(posedge clk_i);
    flag_clr <= 5'h00;
    repeat (20) @(negedge clk_i);
    check({above, below, irq}, 11'h0);
    // sum fills FIFO 1 while the reader stalls, then the chain holds it
    // zero rotation silences every channel, so the local sum is known to be zero
    for (int c = 0; c < 4; c++) nc[c].rot_cos = 16'h0000;
    apply_reset();
    repeat (100) @(negedge clk_i);
    check({acq_valid, overrun}, 2'h3);
    @(posedge clk_i) chain_en <= 1'b1;
    repeat (4) @(posedge clk_i);
    stall <= 1'b0;
    repeat (40) @(negedge clk_i);
    check({acq_valid, 32'(pops)}, {1'b0, 32'd16});
    @(posedge clk_i) chain_in <= {1'b1, 32'h00001234, 32'h00005678};
    for (n = 0; n < 50 && chain_rdy !== 1'b1; n++) @(negedge clk_i);
    check(chain_rdy, 1'b1);
    @(posedge clk_i) chain_in <= {1'b0, 32'hFFFFEDCB, 32'hFFFFA987};
    @(negedge clk_i);
    check(chain_out.valid, 1'b1);
    check({chain_out.i, chain_out.q}, {32'h00001234, 32'h00005678});
    repeat (3) @(negedge clk_i);
    check(32'(pops), 32'd17);
    check(acq_last, 48'h001234005678);
    end_sim();
  end
endmodule
